// File: src/nvsram_i2c_pkg.sv
/*
  Shared constants, state type and address decode for the two-wire
  slave front end of a byte-wide nonvolatile SRAM.
  Assumes a single includer; no timing constants are needed.
*/
`default_nettype none

package nvsram_i2c_pkg;

  localparam int         ADDR_W_DEF    = 13;
  localparam logic [3:0] MEM_FUNC      = 4'ha;
  localparam logic [3:0] CTRL_FUNC     = 4'h3;
  localparam logic [4:0] HS_CODE       = 5'h01;
  localparam logic [3:0] BIT_RST       = 4'h0;
  localparam logic [3:0] BIT_FIRST     = 4'h1;
  localparam logic [3:0] BIT_LAST      = 4'h7;
  localparam logic [3:0] BIT_ACK       = 4'h8;
  localparam logic [7:0] CTRL_READ_VAL = 8'h00;

  // one-hot link states
  typedef enum logic [6:0] {
    idle      = 7'h01,
    get_slave = 7'h02,
    get_hi    = 7'h04,
    get_lo    = 7'h08,
    take_data = 7'h10,
    send_data = 7'h20,
    ignore    = 7'h40
  } link_state_e;

  // function nibble plus two select bits; bit 1 is don't care
  function automatic logic addr_match(input logic [7:0] b,
                                      input logic [1:0] strap);
    return ((b[7:4] == MEM_FUNC) || (b[7:4] == CTRL_FUNC))
           && (b[3:2] == strap);
  endfunction

endpackage

`default_nettype wire

// File: src/nvsram_i2c_slave.sv
/*
  Two-wire slave front end with an 8 K x 8 array behind it.
  Assumes scl_in is the master's bus clock (may stop between frames),
  sda is open drain with an external pull-up, and straps and write
  protect are quasi-static pins.
*/
`timescale 1ns/1ps
`default_nettype none

module nvsram_i2c_slave
  import nvsram_i2c_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF       // memory address width
)(
  input  wire logic       clk,            // system clock, 40 MHz
  input  wire logic       rst,            // synchronous reset, high
  input  wire logic       scl_in,         // bus clock from master
  input  wire logic       sda_in,         // data line level
  output logic            sda_out,        // data drive value (low)
  output logic            sda_oe,         // high while pulling low
  input  wire logic [1:0] select_strap_pins, // select straps
  input  wire logic       wp_pin,         // write protect, high
  output logic            bus_busy,       // start seen, no stop yet
  output logic            hs_mode         // high speed mode active
);

  localparam int MEM_DEPTH = 1 << ADDR_W;

  logic [7:0]        mem [0:MEM_DEPTH-1];
  logic [1:0]        rst_l;
  logic              link_rst;
  logic [1:0]        strap_m;
  logic [1:0]        strap_s;
  logic              wp_m;
  logic              wp_s;
  logic              start_tog = 1'b0;
  logic              stop_tog = 1'b0;
  logic              start_seen;
  logic              new_start;
  logic              hs_tog;
  link_state_e       state;
  link_state_e       next_state;
  logic [3:0]        bitcnt;
  logic [6:0]        shreg;
  logic [7:0]        byte_in;
  logic              ack_ok;
  logic              next_ack;
  logic              is_ctrl;
  logic              data_done;
  logic              next_done;
  logic              incr_req;
  logic              load_req;
  logic              next_load;
  logic              mem_we;
  logic              hs_evt;
  logic [ADDR_W-9:0] addr_hi;
  logic [7:0]        addr_lo;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0]        rd_byte;
  logic [7:0]        txsh;
  logic [2:0]        start_c;
  logic [2:0]        stop_c;
  logic [2:0]        hs_c;
  logic              start_evt;
  logic              stop_evt;
  logic              hs_set;

  // reset and pins brought into the bus clock domain
  always_ff @(posedge scl_in)
  begin
    rst_l   <= {rst_l[0], rst};
    strap_m <= select_strap_pins;
    strap_s <= strap_m;
    wp_m    <= wp_pin;
    wp_s    <= wp_m;
  end
  assign link_rst = rst_l[1];

  // start: data falls while clock high; stop: data rises
  always_ff @(negedge sda_in)
  begin
    if (scl_in)
      start_tog <= ~start_tog;
  end

  always_ff @(posedge sda_in)
  begin
    if (scl_in)
      stop_tog <= ~stop_tog;
  end

  // start toggle settles long before the next clock edge
  always_ff @(posedge scl_in)
  begin
    start_seen <= start_tog;
  end
  assign new_start = start_tog ^ start_seen;
  assign byte_in   = {shreg, sda_in};

  // byte-level decisions, taken on the eighth and ninth bit
  always_comb
  begin
    next_state = state;
    next_ack   = 1'b0;
    next_done  = 1'b0;
    next_load  = 1'b0;
    mem_we     = 1'b0;
    hs_evt     = 1'b0;
    if (new_start)
      next_state = get_slave;
    else if (bitcnt == BIT_ACK)
    begin
      if (state == send_data && sda_in)
        next_state = ignore;
    end
    else if (bitcnt == BIT_LAST)
    begin
      case (state)
        get_slave:
        begin
          if (byte_in[7:3] == HS_CODE)
          begin
            hs_evt     = 1'b1;
            next_state = ignore;
          end
          else if (addr_match(byte_in, strap_s))
          begin
            next_ack = 1'b1;
            if (byte_in[0])
              next_state = send_data;
            else if (byte_in[7:4] == CTRL_FUNC)
              next_state = get_lo;
            else
              next_state = get_hi;
          end
          else
            next_state = ignore;
        end
        get_hi:
        begin
          next_ack   = 1'b1;
          next_state = get_lo;
        end
        get_lo:
        begin
          next_ack   = 1'b1;
          next_load  = ~is_ctrl;
          next_state = take_data;
        end
        take_data:
        begin
          if (wp_s && !is_ctrl)
            next_state = ignore;
          else
          begin
            next_ack  = 1'b1;
            mem_we    = ~is_ctrl;
            next_done = ~is_ctrl;
          end
        end
        send_data:
          next_done = ~is_ctrl;
        default:
          next_state = state;
      endcase
    end
  end

  // state, bit counter and input shifter, sampled on rising clock
  always_ff @(posedge scl_in)
  begin
    if (link_rst)
    begin
      state  <= idle;
      bitcnt <= BIT_RST;
      shreg  <= '0;
    end
    else
    begin
      state <= next_state;
      shreg <= byte_in[6:0];
      if (new_start)
        bitcnt <= BIT_FIRST;
      else if (bitcnt == BIT_ACK)
        bitcnt <= BIT_RST;
      else
        bitcnt <= bitcnt + 1'b1;
    end
  end

  // acknowledge, address load and step requests
  always_ff @(posedge scl_in)
  begin
    if (link_rst)
    begin
      ack_ok    <= 1'b0;
      data_done <= 1'b0;
      incr_req  <= 1'b0;
      load_req  <= 1'b0;
      is_ctrl   <= 1'b0;
      addr_hi   <= '0;
      addr_lo   <= '0;
      hs_tog    <= 1'b0;
    end
    else
    begin
      ack_ok   <= next_ack;
      load_req <= next_load;
      incr_req <= (bitcnt == BIT_ACK) && data_done;
      if (bitcnt == BIT_LAST)
        data_done <= next_done;
      if (state == get_slave && bitcnt == BIT_LAST)
        is_ctrl <= (byte_in[7:4] == CTRL_FUNC);
      if (state == get_hi && bitcnt == BIT_LAST)
        addr_hi <= byte_in[ADDR_W-9:0];
      // whole low byte kept; the shifter holds only bits 7 to 1, bit 0 comes from sda_in
      if (state == get_lo && bitcnt == BIT_LAST)
        addr_lo <= byte_in;
      if (hs_evt)
        hs_tog <= ~hs_tog;
    end
  end

  // array write on the last data bit
  always_ff @(posedge scl_in)
  begin
    if (mem_we)
      mem[addr] <= byte_in;
  end

  assign rd_addr = incr_req ? addr + 1'b1 : addr;
  assign rd_byte = is_ctrl ? CTRL_READ_VAL : mem[rd_addr];

  // address counter, stepped on the falling ninth clock
  always_ff @(negedge scl_in)
  begin
    if (link_rst)
      addr <= '0;
    else if (load_req)
      addr <= {addr_hi, addr_lo};
    else if (incr_req)
      addr <= addr + 1'b1;
  end

  // line drive, changed only while the clock is low
  always_ff @(negedge scl_in)
  begin
    sda_out <= 1'b0;
    if (link_rst || new_start)
    begin
      sda_oe <= 1'b0;
      txsh   <= '0;
    end
    else if (bitcnt == BIT_ACK)
      sda_oe <= ack_ok;
    else if (state == send_data && bitcnt == BIT_RST)
    begin
      sda_oe <= ~rd_byte[7];
      txsh   <= {rd_byte[6:0], 1'b0};
    end
    else if (state == send_data)
    begin
      sda_oe <= ~txsh[7];
      txsh   <= {txsh[6:0], 1'b0};
    end
    else
      sda_oe <= 1'b0;
  end

  // events into the system clock domain by toggle synchronisers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      start_c <= '0;
      stop_c  <= '0;
      hs_c    <= '0;
    end
    else
    begin
      start_c <= {start_c[1:0], start_tog};
      stop_c  <= {stop_c[1:0], stop_tog};
      hs_c    <= {hs_c[1:0], hs_tog};
    end
  end
  assign start_evt = start_c[2] ^ start_c[1];
  assign stop_evt  = stop_c[2] ^ stop_c[1];
  assign hs_set    = hs_c[2] ^ hs_c[1];

  // bus busy from start to stop; a start beats a stop
  always_ff @(posedge clk)
  begin
    if (rst)
      bus_busy <= 1'b0;
    else if (start_evt)
      bus_busy <= 1'b1;
    else if (stop_evt)
      bus_busy <= 1'b0;
  end

  // high speed kept across restarts, left only on stop
  always_ff @(posedge clk)
  begin
    if (rst)
      hs_mode <= 1'b0;
    else if (hs_set)
      hs_mode <= 1'b1;
    else if (stop_evt)
      hs_mode <= 1'b0;
  end

  // checks
  chk_ack_drive: assert property (@(posedge scl_in) disable iff (link_rst)
    (bitcnt == BIT_ACK && ack_ok && !new_start) |-> sda_oe)
    else $error("acknowledge slot not driven");

  chk_read_release: assert property (@(posedge scl_in)
    disable iff (link_rst)
    (state == send_data && bitcnt == BIT_ACK && sda_in && !new_start)
    |=> (state == ignore && !sda_oe))
    else $error("line held after master nack");

  chk_addr_step: assert property (@(negedge scl_in) disable iff (link_rst)
    (incr_req && !load_req) |=> addr == $past(addr) + 1'b1)
    else $error("address did not step by one");

  chk_addr_wrap: assert property (@(negedge scl_in) disable iff (link_rst)
    (incr_req && !load_req && &addr) |=> addr == '0)
    else $error("address did not wrap to zero");

  chk_write_ack: assert property (@(posedge scl_in) disable iff (link_rst)
    (state == take_data && bitcnt == BIT_LAST && !wp_s && !new_start)
    |=> ack_ok ##1 incr_req != is_ctrl)
    else $error("write byte not acknowledged");

  chk_protect_nack: assert property (@(posedge scl_in)
    disable iff (link_rst)
    (state == take_data && bitcnt == BIT_LAST && wp_s && !is_ctrl
     && !new_start) |=> (!ack_ok && state == ignore) ##1 !sda_oe)
    else $error("protected write acknowledged");

  chk_restart: assert property (@(posedge scl_in) disable iff (link_rst)
    new_start |=> (state == get_slave && bitcnt == BIT_FIRST))
    else $error("restart did not reopen address phase");

  chk_foreign_addr: assert property (@(posedge scl_in)
    disable iff (link_rst)
    (state == get_slave && bitcnt == BIT_LAST && !new_start
     && !addr_match(byte_in, strap_s)) |=> !ack_ok ##1 !sda_oe)
    else $error("foreign address acknowledged");

  chk_ignore_quiet: assert property (@(posedge scl_in)
    disable iff (link_rst)
    (state == ignore && $past(state) == ignore) |-> !sda_oe)
    else $error("line driven while not addressed");

  chk_hs_hold: assert property (@(posedge clk) disable iff (rst)
    (hs_mode && !stop_evt) |=> hs_mode)
    else $error("high speed left without stop");

  chk_busy_track: assert property (@(posedge clk) disable iff (rst)
    (start_evt |=> bus_busy) and
    ((stop_evt && !start_evt) |=> !bus_busy))
    else $error("busy flag out of step");

endmodule // nvsram_i2c_slave

`default_nettype wire

// File: dv/i2c_master_model.sv
/*
  Behavioural two-wire bus master: makes scl and pulls sda low.
  Assumes sda is resolved outside with a pull-up; scl idles high.
*/
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
  output logic      scl = 1'b1,     // bus clock, still between frames
  output logic      sda_low = 1'b0, // high while pulling sda low
  input  wire logic sda             // resolved data line
);
  int hp = 24; // half period of the 48 ns bus clock

  // clock with sda high so the link side can leave reset
  task automatic idle(input int n);
    repeat (n)
    begin
      #hp scl = 1'b0;
      #hp scl = 1'b1;
    end
  endtask

  // start or repeated start: sda falls while scl is high
  task automatic start();
    if (scl === 1'b0)
    begin
      #(hp/2) sda_low = 1'b0;
      #(hp/2) scl = 1'b1;
    end
    #(hp/2) sda_low = 1'b1;
    #(hp/2) scl = 1'b0;
  endtask

  // stop: sda rises while scl is high
  task automatic stop();
    #(hp/2) sda_low = 1'b1;
    #(hp/2) scl = 1'b1;
    #(hp/2) sda_low = 1'b0;
    #(hp/2);
  endtask

  // one bit: data set mid-low, sampled at the rising edge
  task automatic bit_io(input logic b, output logic r);
    #(hp/2) sda_low = ~b;
    #(hp/2) scl = 1'b1;
    r = sda;
    #hp scl = 1'b0;
  endtask

  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack_out);
  endtask
endmodule // i2c_master_model

`default_nettype wire

// File: dv/nvsram_i2c_slave_interface_tb.sv
/*
  Self-checking bench for the two-wire slave front end.
  Assumes the master model on scl/sda and a pull-up on sda.
*/
`timescale 1ns/1ps
`default_nettype none

module nvsram_i2c_slave_interface_tb
  import nvsram_i2c_pkg::*;
;
  logic       clk, rst, wp_pin, scl, sda_low, sda_out, sda_oe, a;
  logic       bus_busy, hs_mode;
  logic [1:0] strap;
  logic [7:0] d, rx;
  logic [7:0] bad [3];
  logic [7:0] mem [int];
  int         seed, cur, err_total = 0, samples_checked = 0, cyc = 0;
  wire logic  sda = ~(sda_low | (sda_oe & ~sda_out)); // wired-and

  i2c_master_model i2c_master_model_inst (
    .scl(scl), .sda_low(sda_low), .sda(sda));
  nvsram_i2c_slave nvsram_i2c_slave_inst (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .select_strap_pins(strap), .wp_pin(wp_pin),
    .bus_busy(bus_busy), .hs_mode(hs_mode));

  // 40 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic test_done();
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // address byte with the don't-care select bit set
  function automatic logic [7:0] sel(logic [3:0] fn, logic rd);
    return {fn, strap, 1'b1, rd};
  endfunction

  // one byte from the master, acknowledge compared
  task automatic put(input logic [7:0] b, input logic exp_ack);
    i2c_master_model_inst.xfer(b, 1'b1, rx, a);
    check("ack", {7'h0, exp_ack}, {7'h0, a});
  endtask

  // one byte to the master, compared with the model
  task automatic get(input logic [7:0] exp, input logic nack);
    i2c_master_model_inst.xfer(8'hff, nack, rx, a);
    check("read", exp, rx);
  endtask

  // start, memory write request and two address bytes
  task automatic set_addr(input int at);
    i2c_master_model_inst.start();
    put(sel(MEM_FUNC, 1'b0), 1'b0);
    put({3'h5, at[12:8]}, 1'b0);
    put(at[7:0], 1'b0);
    cur = at;
  endtask

  // current-address read of one byte
  task automatic read_one();
    put(sel(MEM_FUNC, 1'b1), 1'b0);
    get(mem[cur], 1'b1);
    cur = (cur + 1) % 8192;
  endtask

  // cut a hung run short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      test_done();
    end
  end

  // main sequence
  initial
  begin
    seed = 4;
    rst = 1'b1;
    wp_pin = 1'b0;
    strap = 2'($random(seed));
    i2c_master_model_inst.idle(4);
    @(negedge clk);
    rst = 1'b0;
    i2c_master_model_inst.idle(3);
    check("flags", 8'h0, {6'h0, bus_busy, hs_mode});
    // burst write across the top of the array
    set_addr(8190);
    check("busy", 8'h1, {7'h0, bus_busy});
    repeat (5)
    begin
      d = 8'($random(seed));
      put(d, 1'b0);
      mem[cur] = d;
      cur = (cur + 1) % 8192;
    end
    i2c_master_model_inst.stop();
    repeat (8) @(negedge clk);
    check("busy", 8'h0, {7'h0, bus_busy});
    // random read, master nacks the last byte
    set_addr(8190);
    i2c_master_model_inst.start();
    check("busy", 8'h1, {7'h0, bus_busy});
    put(sel(MEM_FUNC, 1'b1), 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      get(mem[cur], i == 2);
      cur = (cur + 1) % 8192;
    end
    #2;
    check("drive", 8'h0, {7'h0, sda_oe});
    i2c_master_model_inst.stop();
    i2c_master_model_inst.start();
    read_one();
    i2c_master_model_inst.stop();
    // foreign function, wrong straps, then ignored traffic
    bad = '{{4'h5, strap, 2'h0}, {MEM_FUNC, ~strap, 2'h0},
            {CTRL_FUNC, ~strap, 2'h1}};
    foreach (bad[k])
    begin
      i2c_master_model_inst.start();
      put(bad[k], 1'b1);
      put(8'h00, 1'b1);
    end
    // control function reads back zero
    i2c_master_model_inst.start();
    put(sel(CTRL_FUNC, 1'b1), 1'b0);
    get(CTRL_READ_VAL, 1'b1);
    i2c_master_model_inst.stop();
    // protected write refused, neither stored nor stepped
    @(negedge clk);
    wp_pin = 1'b1;
    set_addr(0);
    put(8'($random(seed)), 1'b1);
    i2c_master_model_inst.stop();
    @(negedge clk);
    wp_pin = 1'b0;
    i2c_master_model_inst.start();
    read_one();
    i2c_master_model_inst.stop();
    // master code, high speed kept over a repeated start
    i2c_master_model_inst.start();
    put({HS_CODE, 3'($random(seed))}, 1'b1);
    repeat (8) @(negedge clk);
    check("hs", 8'h1, {7'h0, hs_mode});
    i2c_master_model_inst.start();
    read_one();
    check("hs", 8'h1, {7'h0, hs_mode});
    i2c_master_model_inst.stop();
    repeat (8) @(negedge clk);
    check("hs", 8'h0, {7'h0, hs_mode});
    test_done();
  end
endmodule // nvsram_i2c_slave_interface_tb

`default_nettype wire
